// file: hdl/ucfg_bank.sv
// Configuration register bank for serial logical devices D and E.
// Assumes a select register picks the device; reads answer one cycle late.
`timescale 1ns/1ps
`default_nettype none

// Function
// - D and E have independent register sets
// - Activation bit 0 enables; bits 7:1 reserved
// - Base address 100h..FF8h, 8-byte aligned
// - IRQ select low nibble; upper nibble reserved
// - Option bit 6: level or pulse interrupt
// - Option bit 5: original or revised error
// - Clock codes 00 div13, 01 div12
// - Also 24 MHz and 14.769 MHz sources
// - D option bit 7 removes 5ns delay
// - D resets to 02h E0h 03h zeros
// - E resets to 03h E8h 04h zeros
module ucfg_bank
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Register port
	input  wire logic [7:0]  i_dev_sel,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	// Port D configuration outputs
	output logic             o_d_enable,
	output logic      [15:0] o_d_base,
	output logic             o_d_base_ok,
	output logic      [3:0]  o_d_irq_line,
	output logic             o_d_irq_pulse,
	output logic             o_d_new_err,
	output logic      [1:0]  o_d_clk_sel,
	output logic             o_d_rx_delay,
	// Port E configuration outputs
	output logic             o_e_enable,
	output logic      [15:0] o_e_base,
	output logic             o_e_base_ok,
	output logic      [3:0]  o_e_irq_line,
	output logic             o_e_irq_pulse,
	output logic             o_e_new_err,
	output logic      [1:0]  o_e_clk_sel
);

	// ==========================================================
	// Storage, one set per device
	logic [7:0] act_ff   [2];
	logic [7:0] baseh_ff [2];
	logic [7:0] basel_ff [2];
	logic [7:0] irq_ff   [2];
	logic [7:0] opt_ff   [2];
	logic [7:0] nxt_act   [2];
	logic [7:0] nxt_baseh [2];
	logic [7:0] nxt_basel [2];
	logic [7:0] nxt_irq   [2];
	logic [7:0] nxt_opt   [2];
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;

	// Base address legal and aligned
	function automatic logic base_ok(input logic [15:0] b);
		base_ok = (b >= ucfg_pkg::BASE_MIN) && (b <= ucfg_pkg::BASE_MAX)
			&& (b[2:0] == 3'h0);
	endfunction

	// ==========================================================
	// Write path; each device decodes only its own select value
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_dev
			localparam logic [7:0] SEL = (g == 0) ? ucfg_pkg::DEV_D : ucfg_pkg::DEV_E;
			localparam logic [7:0] OMSK = (g == 0) ? ucfg_pkg::OPT_MASK_D
				: ucfg_pkg::OPT_MASK_E;
			logic hit;
			assign hit = i_wr && (i_dev_sel == SEL);

			// Next values; reserved bits are never stored
			always_comb
			begin
				nxt_act[g]   = act_ff[g];
				nxt_baseh[g] = baseh_ff[g];
				nxt_basel[g] = basel_ff[g];
				nxt_irq[g]   = irq_ff[g];
				nxt_opt[g]   = opt_ff[g];
				if (hit)
				begin
					case (i_addr)
						ucfg_pkg::ACT_IDX:   nxt_act[g] = i_wdata & ucfg_pkg::ACT_MASK;
						ucfg_pkg::BASEH_IDX: nxt_baseh[g] = i_wdata;
						ucfg_pkg::BASEL_IDX: nxt_basel[g] = i_wdata;
						ucfg_pkg::IRQ_IDX:   nxt_irq[g] = i_wdata & ucfg_pkg::IRQ_MASK;
						ucfg_pkg::OPT_IDX:   nxt_opt[g] = i_wdata & OMSK;
						default:             nxt_act[g] = act_ff[g];
					endcase
				end
			end

			// Registers with per-device reset values
			always_ff @(posedge i_clk)
			begin
				if (i_rst)
				begin
					act_ff[g]   <= ucfg_pkg::ZERO_RST;
					baseh_ff[g] <= (g == 0) ? ucfg_pkg::D_BASEH_RST
						: ucfg_pkg::E_BASEH_RST;
					basel_ff[g] <= (g == 0) ? ucfg_pkg::D_BASEL_RST : ucfg_pkg::E_BASEL_RST;
					irq_ff[g]   <= (g == 0) ? ucfg_pkg::D_IRQ_RST : ucfg_pkg::E_IRQ_RST;
					opt_ff[g]   <= ucfg_pkg::ZERO_RST;
				end
				else
				begin
					act_ff[g]   <= nxt_act[g];
					baseh_ff[g] <= nxt_baseh[g];
					basel_ff[g] <= nxt_basel[g];
					irq_ff[g]   <= nxt_irq[g];
					opt_ff[g]   <= nxt_opt[g];
				end
			end
		end
	endgenerate

	// ==========================================================
	// Read path; unknown device or index reads zero
	always_comb
	begin
		logic [0:0] k;
		logic       v;
		k = 1'b0;
		v = 1'b1;
		nxt_rdata = 8'h00;
		if (i_dev_sel == ucfg_pkg::DEV_D)
			k = 1'b0;
		else if (i_dev_sel == ucfg_pkg::DEV_E)
			k = 1'b1;
		else
			v = 1'b0;
		if (i_rd && v)
		begin
			case (i_addr)
				ucfg_pkg::ACT_IDX:   nxt_rdata = act_ff[k];
				ucfg_pkg::BASEH_IDX: nxt_rdata = baseh_ff[k];
				ucfg_pkg::BASEL_IDX: nxt_rdata = basel_ff[k];
				ucfg_pkg::IRQ_IDX:   nxt_rdata = irq_ff[k];
				ucfg_pkg::OPT_IDX:   nxt_rdata = opt_ff[k];
				default:             nxt_rdata = 8'h00;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end
	assign o_rdata = rdata_ff;

	// ==========================================================
	// Output registers for port D
	// Every pin comes straight from a flip-flop, so logic downstream sees
	// no glitch from the base window compare. Next values come from the
	// next register contents, which keeps the pins in step with the
	// stored bytes: a write shows on the pins one cycle after its strobe.
	logic        d_enable_ff;
	logic [15:0] d_base_ff;
	logic        d_base_ok_ff;
	logic [3:0]  d_irq_line_ff;
	logic        d_irq_pulse_ff;
	logic        d_new_err_ff;
	logic [1:0]  d_clk_sel_ff;
	logic        d_rx_delay_ff;
	logic        nxt_d_enable;
	logic [15:0] nxt_d_base;
	logic        nxt_d_base_ok;
	logic [3:0]  nxt_d_irq_line;
	logic        nxt_d_irq_pulse;
	logic        nxt_d_new_err;
	logic [1:0]  nxt_d_clk_sel;
	logic        nxt_d_rx_delay;

	// Port D next values from the next register contents
	always_comb
	begin
		nxt_d_enable    = nxt_act[0][ucfg_pkg::ACT_EN_BIT];
		nxt_d_base      = {nxt_baseh[0], nxt_basel[0]};
		nxt_d_base_ok   = base_ok({nxt_baseh[0], nxt_basel[0]});
		nxt_d_irq_line  = nxt_irq[0][3:0];
		nxt_d_irq_pulse = nxt_opt[0][ucfg_pkg::OPT_PULSE_BIT];
		nxt_d_new_err   = nxt_opt[0][ucfg_pkg::OPT_NEWERR_BIT];
		nxt_d_clk_sel   = nxt_opt[0][1:0];
		// High means the 5 ns receive_sample_clock delay is inserted
		nxt_d_rx_delay  = ~nxt_opt[0][ucfg_pkg::OPT_RXDLY_BIT];
	end

	// Port D pins; reset mirrors the register reset values
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			d_enable_ff    <= ucfg_pkg::ZERO_RST[ucfg_pkg::ACT_EN_BIT];
			d_base_ff      <= {ucfg_pkg::D_BASEH_RST, ucfg_pkg::D_BASEL_RST};
			d_base_ok_ff   <= base_ok({ucfg_pkg::D_BASEH_RST, ucfg_pkg::D_BASEL_RST});
			d_irq_line_ff  <= ucfg_pkg::D_IRQ_RST[3:0];
			d_irq_pulse_ff <= ucfg_pkg::ZERO_RST[ucfg_pkg::OPT_PULSE_BIT];
			d_new_err_ff   <= ucfg_pkg::ZERO_RST[ucfg_pkg::OPT_NEWERR_BIT];
			d_clk_sel_ff   <= ucfg_pkg::ZERO_RST[1:0];
			// Option bit 7 resets to zero, so the delay starts inserted
			d_rx_delay_ff  <= ~ucfg_pkg::ZERO_RST[ucfg_pkg::OPT_RXDLY_BIT];
		end
		else
		begin
			d_enable_ff    <= nxt_d_enable;
			d_base_ff      <= nxt_d_base;
			d_base_ok_ff   <= nxt_d_base_ok;
			d_irq_line_ff  <= nxt_d_irq_line;
			d_irq_pulse_ff <= nxt_d_irq_pulse;
			d_new_err_ff   <= nxt_d_new_err;
			d_clk_sel_ff   <= nxt_d_clk_sel;
			d_rx_delay_ff  <= nxt_d_rx_delay;
		end
	end

	// ==========================================================
	// Output registers for port E
	// Same scheme as port D; E has no receive clock delay control, its
	// option bit 7 is reserved and never stored.
	logic        e_enable_ff;
	logic [15:0] e_base_ff;
	logic        e_base_ok_ff;
	logic [3:0]  e_irq_line_ff;
	logic        e_irq_pulse_ff;
	logic        e_new_err_ff;
	logic [1:0]  e_clk_sel_ff;
	logic        nxt_e_enable;
	logic [15:0] nxt_e_base;
	logic        nxt_e_base_ok;
	logic [3:0]  nxt_e_irq_line;
	logic        nxt_e_irq_pulse;
	logic        nxt_e_new_err;
	logic [1:0]  nxt_e_clk_sel;

	// Port E next values from the next register contents
	always_comb
	begin
		nxt_e_enable    = nxt_act[1][ucfg_pkg::ACT_EN_BIT];
		nxt_e_base      = {nxt_baseh[1], nxt_basel[1]};
		nxt_e_base_ok   = base_ok({nxt_baseh[1], nxt_basel[1]});
		nxt_e_irq_line  = nxt_irq[1][3:0];
		nxt_e_irq_pulse = nxt_opt[1][ucfg_pkg::OPT_PULSE_BIT];
		nxt_e_new_err   = nxt_opt[1][ucfg_pkg::OPT_NEWERR_BIT];
		nxt_e_clk_sel   = nxt_opt[1][1:0];
	end

	// Port E pins; reset mirrors the register reset values
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			e_enable_ff    <= ucfg_pkg::ZERO_RST[ucfg_pkg::ACT_EN_BIT];
			e_base_ff      <= {ucfg_pkg::E_BASEH_RST, ucfg_pkg::E_BASEL_RST};
			e_base_ok_ff   <= base_ok({ucfg_pkg::E_BASEH_RST, ucfg_pkg::E_BASEL_RST});
			e_irq_line_ff  <= ucfg_pkg::E_IRQ_RST[3:0];
			e_irq_pulse_ff <= ucfg_pkg::ZERO_RST[ucfg_pkg::OPT_PULSE_BIT];
			e_new_err_ff   <= ucfg_pkg::ZERO_RST[ucfg_pkg::OPT_NEWERR_BIT];
			e_clk_sel_ff   <= ucfg_pkg::ZERO_RST[1:0];
		end
		else
		begin
			e_enable_ff    <= nxt_e_enable;
			e_base_ff      <= nxt_e_base;
			e_base_ok_ff   <= nxt_e_base_ok;
			e_irq_line_ff  <= nxt_e_irq_line;
			e_irq_pulse_ff <= nxt_e_irq_pulse;
			e_new_err_ff   <= nxt_e_new_err;
			e_clk_sel_ff   <= nxt_e_clk_sel;
		end
	end

	// ==========================================================
	// Pins, straight from the output registers
	assign o_d_enable    = d_enable_ff;
	assign o_d_base      = d_base_ff;
	assign o_d_base_ok   = d_base_ok_ff;
	assign o_d_irq_line  = d_irq_line_ff;
	assign o_d_irq_pulse = d_irq_pulse_ff;
	assign o_d_new_err   = d_new_err_ff;
	assign o_d_clk_sel   = d_clk_sel_ff;
	assign o_d_rx_delay  = d_rx_delay_ff;
	assign o_e_enable    = e_enable_ff;
	assign o_e_base      = e_base_ff;
	assign o_e_base_ok   = e_base_ok_ff;
	assign o_e_irq_line  = e_irq_line_ff;
	assign o_e_irq_pulse = e_irq_pulse_ff;
	assign o_e_new_err   = e_new_err_ff;
	assign o_e_clk_sel   = e_clk_sel_ff;

endmodule
`default_nettype wire

// file: hdl/ucfg_pkg.sv
// Constants for the two-port serial configuration register bank.
// Assumes a byte-wide configuration port and one 100 MHz clock.
package ucfg_pkg;

	// ==========================================================
	// Register indices within one logical device
	localparam logic [7:0] ACT_IDX   = 8'h30;
	localparam logic [7:0] BASEH_IDX = 8'h60;
	localparam logic [7:0] BASEL_IDX = 8'h61;
	localparam logic [7:0] IRQ_IDX   = 8'h70;
	localparam logic [7:0] OPT_IDX   = 8'hF0;

	// ==========================================================
	// Logical device numbers on the select port
	localparam logic [7:0] DEV_D = 8'h0D;
	localparam logic [7:0] DEV_E = 8'h0E;

	// ==========================================================
	// Field positions
	localparam int ACT_EN_BIT    = 0;
	localparam int OPT_RXDLY_BIT = 7;
	localparam int OPT_PULSE_BIT = 6;
	localparam int OPT_NEWERR_BIT = 5;
	localparam logic [7:0] ACT_MASK   = 8'h01;
	localparam logic [7:0] IRQ_MASK   = 8'h0F;
	localparam logic [7:0] OPT_MASK_D = 8'hE3;
	localparam logic [7:0] OPT_MASK_E = 8'h63;

	// ==========================================================
	// Reset values
	localparam logic [7:0] D_BASEH_RST = 8'h02;
	localparam logic [7:0] D_BASEL_RST = 8'hE0;
	localparam logic [7:0] D_IRQ_RST   = 8'h03;
	localparam logic [7:0] E_BASEH_RST = 8'h03;
	localparam logic [7:0] E_BASEL_RST = 8'hE8;
	localparam logic [7:0] E_IRQ_RST   = 8'h04;
	localparam logic [7:0] ZERO_RST    = 8'h00;

	// ==========================================================
	// Base address window and clock source codes
	localparam logic [15:0] BASE_MIN = 16'h0100;
	localparam logic [15:0] BASE_MAX = 16'h0FF8;
	localparam logic [1:0]  CLK_DIV13 = 2'h0;
	localparam logic [1:0]  CLK_DIV12 = 2'h1;
	localparam logic [1:0]  CLK_DIV1  = 2'h2;
	localparam logic [1:0]  CLK_14M   = 2'h3;

endpackage

// file: bench/ucfg_bank_checker.sv
// Port checks for the two-port serial configuration bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module ucfg_bank_checker
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Register port
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [7:0]  i_dev_sel,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic [7:0]  o_rdata,
	// Watched configuration outputs
	input  wire logic        o_d_enable,
	input  wire logic        o_d_base_ok,
	input  wire logic        o_d_irq_pulse,
	input  wire logic        o_d_new_err,
	input  wire logic        o_d_rx_delay,
	input  wire logic [1:0]  o_d_clk_sel,
	input  wire logic [15:0] o_d_base,
	input  wire logic [15:0] o_e_base,
	input  wire logic [3:0]  o_e_irq_line
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Decoded selects keep the properties short
	wire logic sel_d = (i_dev_sel == ucfg_pkg::DEV_D);
	wire logic sel_e = (i_dev_sel == ucfg_pkg::DEV_E);
	wire logic [7:0] d_opt = {!o_d_rx_delay, o_d_irq_pulse, o_d_new_err, 3'h0, o_d_clk_sel};
	sequence s_rd_opt; i_rd && sel_d && i_addr == ucfg_pkg::OPT_IDX; endsequence
	sequence s_wr_opt; i_wr && sel_d && i_addr == ucfg_pkg::OPT_IDX; endsequence
	property p_rst_val;
		$fell(i_rst) |-> o_d_base == 16'h02E0 && o_e_base == 16'h03E8
			&& o_e_irq_line == 4'h4;
	endproperty
	a_rst_val: assert property (p_rst_val) else $error("reset value wrong");
	property p_rd_act;
		i_rd && sel_d && i_addr == ucfg_pkg::ACT_IDX |=> o_rdata == {7'h00, o_d_enable};
	endproperty
	a_rd_act: assert property (p_rd_act) else $error("activation read wrong");
	property p_wr_act;
		i_wr && sel_d && i_addr == ucfg_pkg::ACT_IDX
			|=> {7'h00, o_d_enable} == ($past(i_wdata) & 8'h01);
	endproperty
	a_wr_act: assert property (p_wr_act) else $error("activation write wrong");
	property p_rd_opt;
		s_rd_opt |=> o_rdata == d_opt;
	endproperty
	a_rd_opt: assert property (p_rd_opt) else $error("option read wrong");
	property p_wr_opt;
		s_wr_opt |=> d_opt == ($past(i_wdata) & 8'hE3);
	endproperty
	a_wr_opt: assert property (p_wr_opt) else $error("option write wrong");
	property p_wr_irq;
		i_wr && sel_e && i_addr == ucfg_pkg::IRQ_IDX
			|=> {4'h0, o_e_irq_line} == ($past(i_wdata) & 8'h0F);
	endproperty
	a_wr_irq: assert property (p_wr_irq) else $error("irq select write wrong");
	property p_base_ok;
		o_d_base_ok == (o_d_base >= 16'h0100 && o_d_base <= 16'h0FF8
			&& o_d_base[2:0] == 3'h0);
	endproperty
	a_base_ok: assert property (p_base_ok) else $error("base check wrong");
	property p_indep;
		i_wr && sel_d |=> $stable(o_e_base) && $stable(o_e_irq_line);
	endproperty
	a_indep: assert property (p_indep) else $error("port E moved on D write");
endmodule
bind ucfg_bank ucfg_bank_checker u_ucfg_bank_checker
(
	.i_clk         (i_clk),
	.i_rst         (i_rst),
	.i_wr          (i_wr),
	.i_rd          (i_rd),
	.i_dev_sel     (i_dev_sel),
	.i_addr        (i_addr),
	.i_wdata       (i_wdata),
	.o_rdata       (o_rdata),
	.o_d_enable    (o_d_enable),
	.o_d_base_ok   (o_d_base_ok),
	.o_d_irq_pulse (o_d_irq_pulse),
	.o_d_new_err   (o_d_new_err),
	.o_d_rx_delay  (o_d_rx_delay),
	.o_d_clk_sel   (o_d_clk_sel),
	.o_d_base      (o_d_base),
	.o_e_base      (o_e_base),
	.o_e_irq_line  (o_e_irq_line)
);
`default_nettype wire

// file: bench/ucfg_bank_tb.sv
// Bench for the serial configuration bank.
// Drives the register port itself; no partner model.
`timescale 1ns/1ps
`default_nettype none
module ucfg_bank_tb;
	logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic [7:0] i_dev_sel = 8'h00, i_addr = 8'h00, i_wdata = 8'h00, o_rdata, dat;
	logic o_d_enable, o_d_base_ok, o_d_irq_pulse, o_d_new_err, o_d_rx_delay;
	logic o_e_enable, o_e_base_ok, o_e_irq_pulse, o_e_new_err;
	logic [15:0] o_d_base, o_e_base;
	logic [3:0] o_d_irq_line, o_e_irq_line;
	logic [1:0] o_d_clk_sel, o_e_clk_sel, cc;
	int errors = 0, checked = 0;
	localparam logic [7:0] D = ucfg_pkg::DEV_D, E = ucfg_pkg::DEV_E;
	logic [7:0] idx [5] = '{ucfg_pkg::ACT_IDX, ucfg_pkg::BASEH_IDX, ucfg_pkg::BASEL_IDX,
		ucfg_pkg::IRQ_IDX, ucfg_pkg::OPT_IDX};
	logic [7:0] rst_d [5] = '{8'h00, 8'h02, 8'hE0, 8'h03, 8'h00};
	logic [7:0] rst_e [5] = '{8'h00, 8'h03, 8'hE8, 8'h04, 8'h00};
	logic [7:0] msk_d [5] = '{8'h01, 8'hFF, 8'hFF, 8'h0F, 8'hE3};
	logic [7:0] msk_e [5] = '{8'h01, 8'hFF, 8'hFF, 8'h0F, 8'h63};
	logic [15:0] bv [5] = '{16'h0100, 16'h0FF8, 16'h00F8, 16'h0FFC, 16'h1000};
	ucfg_bank u_ucfg_bank (.i_clk(i_clk), .i_rst(i_rst), .i_dev_sel(i_dev_sel), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_d_enable(o_d_enable),
		.o_d_base(o_d_base), .o_d_base_ok(o_d_base_ok), .o_d_irq_line(o_d_irq_line),
		.o_d_irq_pulse(o_d_irq_pulse), .o_d_new_err(o_d_new_err), .o_d_clk_sel(o_d_clk_sel),
		.o_d_rx_delay(o_d_rx_delay), .o_e_enable(o_e_enable), .o_e_base(o_e_base),
		.o_e_base_ok(o_e_base_ok), .o_e_irq_line(o_e_irq_line), .o_e_irq_pulse(o_e_irq_pulse),
		.o_e_new_err(o_e_new_err), .o_e_clk_sel(o_e_clk_sel));
	// ==========================================================
	// Clock, tasks and watchdog
	initial forever #5 i_clk = ~i_clk;
	task automatic finish_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One-cycle strobes; outputs looked at just after the taking edge
	task automatic wr(input logic [7:0] s, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		{i_dev_sel, i_addr, i_wdata, i_wr} <= {s, a, d, 1'b1};
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] s, input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		{i_dev_sel, i_addr, i_rd} <= {s, a, 1'b1};
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, e);
	endtask
	initial
	begin
		repeat (5000) @(posedge i_clk);
		errors++;
		finish_test();
	end
	// ==========================================================
	// Tests
	initial
	begin
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		chk({7'h00, o_d_rx_delay}, 8'h01);
		for (int i = 0; i < 5; i++)
		begin
			rd(D, idx[i], rst_d[i]);
			rd(E, idx[i], rst_e[i]);
		end
		$display("test reset done");
		// All ones: reserved bits drop, port E stays put on a D write
		for (int i = 0; i < 5; i++)
		begin
			wr(D, idx[i], 8'hFF);
			rd(D, idx[i], msk_d[i]);
			rd(E, idx[i], rst_e[i]);
			wr(E, idx[i], 8'hFF);
			rd(E, idx[i], msk_e[i]);
		end
		// Port D pins after all ones: delay removed, base FFFF out of window
		chk({7'h00, o_d_rx_delay}, 8'h00);
		chk({4'h0, o_d_irq_line}, 8'h0F);
		chk(o_d_base[15:8], 8'hFF);
		chk(o_d_base[7:0], 8'hFF);
		chk({7'h00, o_d_base_ok}, 8'h00);
		$display("test masks done");
		// Every clock code, with the two mode bits walked beside it
		for (int c = 0; c < 4; c++)
		begin
			cc = 2'(c);
			dat = {1'b0, cc[0], cc[1], 3'h0, cc};
			wr(D, ucfg_pkg::OPT_IDX, dat);
			chk({1'b0, o_d_irq_pulse, o_d_new_err, 5'h00}, dat & 8'h60);
			chk({6'h00, o_d_clk_sel}, {6'h00, cc});
			wr(E, ucfg_pkg::OPT_IDX, dat);
			chk({1'b0, o_e_irq_pulse, o_e_new_err, 5'h00}, dat & 8'h60);
			chk({6'h00, o_e_clk_sel}, {6'h00, cc});
		end
		$display("test options done");
		// Base window edges: only the first two are legal
		for (int j = 0; j < 5; j++)
		begin
			wr(E, ucfg_pkg::BASEH_IDX, bv[j][15:8]);
			wr(E, ucfg_pkg::BASEL_IDX, bv[j][7:0]);
			chk({7'h00, o_e_base_ok}, (j < 2) ? 8'h01 : 8'h00);
		end
		$display("test base done");
		// Unknown device and index are ignored
		wr(8'h0F, ucfg_pkg::ACT_IDX, 8'h00);
		chk({6'h00, o_d_enable, o_e_enable}, 8'h03);
		rd(D, 8'h31, 8'h00);
		$display("test refusal done");
		finish_test();
	end
endmodule
`default_nettype wire
